// >>> aat_consts.svh
/*
  constants of the analog alarm and tube detector block: register offsets,
  reset values, field widths and timing.
  assumes it is included by bare name wherever a constant is needed.
*/
`ifndef AAT_CONSTS_SVH
`define AAT_CONSTS_SVH

// data path and mode field widths
`define AAT_DW 16
`define AAT_ALM_MSB 1
`define AAT_SRC_MSB 3
`define AAT_EYE_MSB 2
`define AAT_ADDR_W 8

// timing: one persistence tick is a millisecond
`define AAT_CLK_MHZ 100
`define AAT_TICK_US 1000

// register byte offsets
`define AAT_OFF_LOW_MODE 8'h00
`define AAT_OFF_LOW_LIMIT 8'h04
`define AAT_OFF_HIGH_MODE 8'h08
`define AAT_OFF_HIGH_LIMIT 8'h0C
`define AAT_OFF_ALARM_TIME 8'h10
`define AAT_OFF_IN_CAL_LO 8'h14
`define AAT_OFF_IN_CAL_HI 8'h18
`define AAT_OFF_IN_VALUE 8'h1C
`define AAT_OFF_OUT_VALUE 8'h20
`define AAT_OFF_OUT_SRC 8'h24
`define AAT_OFF_OUT_FORCED 8'h28
`define AAT_OFF_OUT_CAL_LO 8'h2C
`define AAT_OFF_OUT_CAL_HI 8'h30
`define AAT_OFF_EYE_READ 8'h34
`define AAT_OFF_EYE_STATE 8'h38
`define AAT_OFF_EYE_MODE 8'h3C
`define AAT_OFF_DET_TIME 8'h40
`define AAT_OFF_LIQ_THR 8'h44
`define AAT_OFF_AIR_THR 8'h48
`define AAT_OFF_EVENTS 8'h4C

// reset values and loop current end points
`define AAT_RST_LOW_LIMIT 16'h1000
`define AAT_RST_HIGH_LIMIT 16'hF000
`define AAT_RST_TIME 16'h000A
`define AAT_RST_CAL_LO 16'h0000
`define AAT_RST_CAL_HI 16'hFFFF
`define AAT_RST_LIQ_THR 16'hC000
`define AAT_RST_AIR_THR 16'h4000
`define AAT_LEVEL_4MA 16'h0000
`define AAT_LEVEL_20MA 16'hFFFF

`endif

// >>> aat_pkg.sv
/*
  types of the analog alarm and tube detector block: modes, states and
  the packed structs that carry grouped signals and module state.
  assumes aat_consts.svh is on the include path.
*/
`default_nettype none
`include "aat_consts.svh"
package aat_pkg;
  typedef logic [`AAT_DW-1:0] aat_word_t;
  typedef enum logic [`AAT_ALM_MSB:0] {
    AAT_ALM_OFF, AAT_ALM_ALERT, AAT_ALM_FAULT
  } aat_alm_mode_t;
  typedef enum logic [`AAT_SRC_MSB:0] {
    AAT_SRC_OFF, AAT_SRC_ACTUAL, AAT_SRC_DISP_RATE, AAT_SRC_FEEDER,
    AAT_SRC_MAINT, AAT_SRC_DISP_VOL, AAT_SRC_PISTON, AAT_SRC_REPEAT,
    AAT_SRC_FORCED, AAT_SRC_CAL_LO, AAT_SRC_CAL_HI
  } aat_src_t;
  typedef enum logic [`AAT_EYE_MSB:0] {
    AAT_EYE_OFF, AAT_EYE_TUNE_AIR, AAT_EYE_TUNE_LIQ, AAT_EYE_STATUS,
    AAT_EYE_ALERT_AIR, AAT_EYE_FAULT_AIR
  } aat_eye_mode_t;
  typedef enum logic [`AAT_EYE_MSB:0] {
    AAT_ST_BLANK, AAT_ST_AIR, AAT_ST_LIQUID, AAT_ST_NO_SENSOR,
    AAT_ST_TUNE_AIR, AAT_ST_TUNE_LIQ
  } aat_eye_state_t;
  typedef enum logic [1:0] {AAT_PH_NONE, AAT_PH_AIR, AAT_PH_LIQ} aat_phase_t;
  // process quantities that may drive the analog output
  typedef struct packed {
    aat_word_t actual_rate, dispense_rate, feeder_rate;
    aat_word_t maint_setpoint, dispense_volume, piston_pos;
  } aat_proc_t;
  // alert and fault outputs
  typedef struct packed {
    logic eye_fault, eye_alert, high_fault, high_alert, low_fault, low_alert;
  } aat_events_t;
  typedef struct packed {logic [`AAT_DW:0] cnt; logic qual;} aat_pst_t;
  typedef struct packed {aat_word_t y;} aat_cal_st_t;
  typedef struct packed {
    aat_alm_mode_t low_mode, high_mode;
    aat_word_t low_limit, high_limit, alarm_time, in_cal_lo, in_cal_hi;
    aat_src_t out_src;
    aat_word_t out_forced, out_cal_lo, out_cal_hi, out_level;
    logic out_en;
    aat_eye_mode_t eye_mode;
    aat_word_t det_time, liq_thr, air_thr;
    aat_word_t ain_s1, ain_s2, eye_s1, eye_s2;
    logic ns_s1, ns_s2, tick;
    logic [31:0] tick_cnt;
    aat_phase_t phase;
    aat_eye_state_t eye_state;
    aat_events_t ev;
    logic [31:0] rdata;
    logic err;
  } aat_state_t;
endpackage
`default_nettype wire

// >>> aat_cal.sv
/*
  two-point slope and offset correction: y = y0 + (x-x0)*(y1-y0)/(x1-x0),
  clamped to the word range and registered.
  assumes all inputs come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aat_consts.svh"
module aat_cal (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire aat_pkg::aat_word_t x, // value to correct
  input wire aat_pkg::aat_word_t x0, // low point, x side
  input wire aat_pkg::aat_word_t x1, // high point, x side
  input wire aat_pkg::aat_word_t y0, // low point, y side
  input wire aat_pkg::aat_word_t y1, // high point, y side
  output aat_pkg::aat_word_t y // corrected value, one cycle later
);
  aat_pkg::aat_cal_st_t q, n;
  logic signed [`AAT_DW+1:0] dx, sx, sy;
  logic signed [2*`AAT_DW+3:0] prod, quot, res;

  // straight line through both points; equal points fall back to y0
  always_comb begin
    dx = $signed({2'b00, x}) - $signed({2'b00, x0});
    sx = $signed({2'b00, x1}) - $signed({2'b00, x0});
    sy = $signed({2'b00, y1}) - $signed({2'b00, y0});
    prod = dx * sy;
    quot = (sx == '0) ? '0 : prod / sx;
    res = quot + $signed({{(`AAT_DW+4){1'b0}}, y0});
    n = q;
    if (res[2*`AAT_DW+3]) begin
      n.y = '0;
    end else if (|res[2*`AAT_DW+2:`AAT_DW]) begin
      n.y = '1;
    end else begin
      n.y = res[`AAT_DW-1:0];
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '0;
    else q <= n;
  end

  assign y = q.y;
endmodule
`default_nettype wire

// >>> aat_persist.sv
/*
  persistence qualifier: qual rises once cond has held for more than
  limit whole ticks; any drop of cond restarts the count.
  assumes tick is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aat_consts.svh"
module aat_persist (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic cond, // raw condition
  input wire logic tick, // time base pulse
  input wire aat_pkg::aat_word_t limit, // hold time in ticks
  output logic qual // condition qualified
);
  aat_pkg::aat_pst_t q, n;

  // count ticks while cond holds, clear on any gap
  always_comb begin
    n = q;
    if (!cond) begin
      n.cnt = '0;
      n.qual = 1'b0;
    end else if ({1'b0, limit} < q.cnt) begin
      n.qual = 1'b1;
    end else if (tick) begin
      n.cnt = q.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '0;
    else q <= n;
  end

  assign qual = q.qual;
endmodule
`default_nettype wire

// >>> aat_monitor.sv
/*
  analog alarm and tube detector: 4-20mA input alarms with persistence,
  analog output source selection with calibration, optical tube detector
  classification, all reached over an APB slave.
  assumes the adc, detector and no-sensor pins are asynchronous and that
  multi-bit pin words hold steady for several clocks per sample; process
  quantities come from logic on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aat_consts.svh"
// Contract
// R1: low alarm when input at or below limit
// R2: high alarm when input at or above limit
// R3: alarm fires only after the persistence time
// R4: returning within limits restarts the delay
// R5: input corrected by two-point slope and offset
// R6: present output value readable as status
// R7: output sources off, actual rate, dispense rate
// R8: output sources feeder rate, maintainer setpoint
// R9: output sources dispense volume, piston position
// R10: repeat mode copies the analog input
// R11: forced mode drives the stored force level
// R12: calibration modes force 4mA or 20mA
// R13: output corrected by two-point slope and offset
// R14: detector reading readable as status
// R15: air reported when reading below air threshold
// R16: liquid reported when reading above liquid threshold
// R17: no-sensor and blank states reported
// R18: tuning modes report tuning air or liquid
// R19: tuning stores the threshold from the reading
// R20: status mode raises no alert or fault
// R21: alert or fault on air per mode
// R22: detector state changes after detection time
// R23: liquid threshold writable and used afterwards
module aat_monitor #(
  parameter int TICK_CYCLES = `AAT_TICK_US * `AAT_CLK_MHZ // cycles per tick
) (
  input wire logic pclk, // clock, 100 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [`AAT_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire aat_pkg::aat_word_t ain_raw, // raw adc word, pin
  input wire aat_pkg::aat_word_t eye_raw, // detector reading, pin
  input wire logic eye_no_sensor, // detector reports no sensor, pin
  input wire aat_pkg::aat_proc_t proc, // process quantities
  output aat_pkg::aat_word_t dac_code, // corrected output code
  output logic dac_enable, // analog output driven
  output aat_pkg::aat_events_t events // alerts and faults
);
  aat_pkg::aat_state_t q, n;
  aat_pkg::aat_word_t ain_val;
  logic low_hit, high_hit, air_hit, liq_hit;
  logic low_q, high_q, air_q, liq_q;
  logic eye_run, apb_wr, apb_setup;

  // zero-wait apb: read data is captured in the setup cycle
  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;

  // analog input correction against the stored input points
  aat_cal u_in_cal (
    .pclk(pclk),
    .presetn(presetn),
    .x(q.ain_s2),
    .x0(q.in_cal_lo),
    .x1(q.in_cal_hi),
    .y0(`AAT_LEVEL_4MA),
    .y1(`AAT_LEVEL_20MA),
    .y(ain_val)
  ); // R5

  // analog output correction toward the stored output points
  aat_cal u_out_cal (
    .pclk(pclk),
    .presetn(presetn),
    .x(q.out_level),
    .x0(`AAT_LEVEL_4MA),
    .x1(`AAT_LEVEL_20MA),
    .y0(q.out_cal_lo),
    .y1(q.out_cal_hi),
    .y(dac_code)
  ); // R13

  // limit comparisons, gated by the alarm selectors
  assign low_hit = (q.low_mode != aat_pkg::AAT_ALM_OFF) &&
    (ain_val <= q.low_limit); // R1
  assign high_hit = (q.high_mode != aat_pkg::AAT_ALM_OFF) &&
    (ain_val >= q.high_limit); // R2

  // detector comparisons only while classifying with a sensor present
  assign eye_run = (q.eye_mode == aat_pkg::AAT_EYE_STATUS) ||
    (q.eye_mode == aat_pkg::AAT_EYE_ALERT_AIR) ||
    (q.eye_mode == aat_pkg::AAT_EYE_FAULT_AIR);
  assign air_hit = eye_run && !q.ns_s2 && (q.eye_s2 < q.air_thr); // R15
  assign liq_hit = eye_run && !q.ns_s2 && (q.eye_s2 > q.liq_thr); // R16

  // persistence of each alarm; a gap clears the count
  aat_persist u_low (
    .pclk(pclk),
    .presetn(presetn),
    .cond(low_hit),
    .tick(q.tick),
    .limit(q.alarm_time),
    .qual(low_q)
  ); // R3 R4

  aat_persist u_high (
    .pclk(pclk),
    .presetn(presetn),
    .cond(high_hit),
    .tick(q.tick),
    .limit(q.alarm_time),
    .qual(high_q)
  ); // R3 R4

  // detection time for the air and liquid detector states
  aat_persist u_air (
    .pclk(pclk),
    .presetn(presetn),
    .cond(air_hit),
    .tick(q.tick),
    .limit(q.det_time),
    .qual(air_q)
  ); // R22

  aat_persist u_liq (
    .pclk(pclk),
    .presetn(presetn),
    .cond(liq_hit),
    .tick(q.tick),
    .limit(q.det_time),
    .qual(liq_q)
  ); // R22

  // next state: sync, time base, registers, output mux, detector, events
  always_comb begin
    n = q;
    // two-stage synchronisers for the pins
    n.ain_s1 = ain_raw;
    n.ain_s2 = q.ain_s1;
    n.eye_s1 = eye_raw;
    n.eye_s2 = q.eye_s1;
    n.ns_s1 = eye_no_sensor;
    n.ns_s2 = q.ns_s1;
    // millisecond tick
    n.tick = 1'b0;
    if (q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 32'h0000_0001;
    end
    // software writes
    if (apb_wr) begin
      case (paddr)
        `AAT_OFF_LOW_MODE:
          n.low_mode = aat_pkg::aat_alm_mode_t'(pwdata[`AAT_ALM_MSB:0]);
        `AAT_OFF_LOW_LIMIT: n.low_limit = pwdata[`AAT_DW-1:0];
        `AAT_OFF_HIGH_MODE:
          n.high_mode = aat_pkg::aat_alm_mode_t'(pwdata[`AAT_ALM_MSB:0]);
        `AAT_OFF_HIGH_LIMIT: n.high_limit = pwdata[`AAT_DW-1:0];
        `AAT_OFF_ALARM_TIME: n.alarm_time = pwdata[`AAT_DW-1:0];
        `AAT_OFF_IN_CAL_LO: n.in_cal_lo = pwdata[`AAT_DW-1:0];
        `AAT_OFF_IN_CAL_HI: n.in_cal_hi = pwdata[`AAT_DW-1:0];
        `AAT_OFF_OUT_SRC:
          n.out_src = aat_pkg::aat_src_t'(pwdata[`AAT_SRC_MSB:0]);
        `AAT_OFF_OUT_FORCED: n.out_forced = pwdata[`AAT_DW-1:0];
        `AAT_OFF_OUT_CAL_LO: n.out_cal_lo = pwdata[`AAT_DW-1:0];
        `AAT_OFF_OUT_CAL_HI: n.out_cal_hi = pwdata[`AAT_DW-1:0];
        `AAT_OFF_EYE_MODE:
          n.eye_mode = aat_pkg::aat_eye_mode_t'(pwdata[`AAT_EYE_MSB:0]);
        `AAT_OFF_DET_TIME: n.det_time = pwdata[`AAT_DW-1:0];
        `AAT_OFF_LIQ_THR: n.liq_thr = pwdata[`AAT_DW-1:0]; // R23
        `AAT_OFF_AIR_THR: n.air_thr = pwdata[`AAT_DW-1:0];
        default: n.err = q.err;
      endcase
    end
    // tuning captures the live reading and wins over a software write
    if (q.eye_mode == aat_pkg::AAT_EYE_TUNE_AIR) begin
      n.air_thr = q.eye_s2; // R19
    end
    if (q.eye_mode == aat_pkg::AAT_EYE_TUNE_LIQ) begin
      n.liq_thr = q.eye_s2; // R19
    end
    // output source selection
    n.out_en = 1'b1;
    case (q.out_src)
      aat_pkg::AAT_SRC_ACTUAL: n.out_level = proc.actual_rate; // R7
      aat_pkg::AAT_SRC_DISP_RATE: n.out_level = proc.dispense_rate; // R7
      aat_pkg::AAT_SRC_FEEDER: n.out_level = proc.feeder_rate; // R8
      aat_pkg::AAT_SRC_MAINT: n.out_level = proc.maint_setpoint; // R8
      aat_pkg::AAT_SRC_DISP_VOL: n.out_level = proc.dispense_volume; // R9
      aat_pkg::AAT_SRC_PISTON: n.out_level = proc.piston_pos; // R9
      aat_pkg::AAT_SRC_REPEAT: n.out_level = ain_val; // R10
      aat_pkg::AAT_SRC_FORCED: n.out_level = q.out_forced; // R11
      aat_pkg::AAT_SRC_CAL_LO: n.out_level = `AAT_LEVEL_4MA; // R12
      aat_pkg::AAT_SRC_CAL_HI: n.out_level = `AAT_LEVEL_20MA; // R12
      default: begin
        // off or an unused code: output parked at the bottom, undriven
        n.out_level = `AAT_LEVEL_4MA; // R7
        n.out_en = 1'b0;
      end
    endcase
    // detector air or liquid phase, held between decisions
    if (!eye_run || q.ns_s2) begin
      n.phase = aat_pkg::AAT_PH_NONE;
    end else if (air_q) begin
      n.phase = aat_pkg::AAT_PH_AIR; // R22
    end else if (liq_q) begin
      n.phase = aat_pkg::AAT_PH_LIQ; // R22
    end
    // reported detector state
    case (q.eye_mode)
      aat_pkg::AAT_EYE_TUNE_AIR: n.eye_state = aat_pkg::AAT_ST_TUNE_AIR; // R18
      aat_pkg::AAT_EYE_TUNE_LIQ: n.eye_state = aat_pkg::AAT_ST_TUNE_LIQ; // R18
      aat_pkg::AAT_EYE_STATUS, aat_pkg::AAT_EYE_ALERT_AIR,
      aat_pkg::AAT_EYE_FAULT_AIR: begin
        if (q.ns_s2) begin
          n.eye_state = aat_pkg::AAT_ST_NO_SENSOR; // R17
        end else if (q.phase == aat_pkg::AAT_PH_AIR) begin
          n.eye_state = aat_pkg::AAT_ST_AIR; // R15
        end else if (q.phase == aat_pkg::AAT_PH_LIQ) begin
          n.eye_state = aat_pkg::AAT_ST_LIQUID; // R16
        end else begin
          n.eye_state = aat_pkg::AAT_ST_BLANK;
        end
      end
      default: n.eye_state = aat_pkg::AAT_ST_BLANK; // R17
    endcase
    // alerts and faults, by selector
    n.ev.low_alert = low_q && (q.low_mode == aat_pkg::AAT_ALM_ALERT); // R1
    n.ev.low_fault = low_q && (q.low_mode == aat_pkg::AAT_ALM_FAULT); // R1
    n.ev.high_alert = high_q && (q.high_mode == aat_pkg::AAT_ALM_ALERT); // R2
    n.ev.high_fault = high_q && (q.high_mode == aat_pkg::AAT_ALM_FAULT); // R2
    // status mode sets neither, only the air modes do
    n.ev.eye_alert = (q.eye_state == aat_pkg::AAT_ST_AIR) &&
      (q.eye_mode == aat_pkg::AAT_EYE_ALERT_AIR); // R20 R21
    n.ev.eye_fault = (q.eye_state == aat_pkg::AAT_ST_AIR) &&
      (q.eye_mode == aat_pkg::AAT_EYE_FAULT_AIR); // R20 R21
    // read data and error, captured in the setup cycle
    if (apb_setup) begin
      n.rdata = '0;
      n.err = 1'b0;
      case (paddr)
        `AAT_OFF_LOW_MODE: n.rdata = 32'(q.low_mode);
        `AAT_OFF_LOW_LIMIT: n.rdata = 32'(q.low_limit);
        `AAT_OFF_HIGH_MODE: n.rdata = 32'(q.high_mode);
        `AAT_OFF_HIGH_LIMIT: n.rdata = 32'(q.high_limit);
        `AAT_OFF_ALARM_TIME: n.rdata = 32'(q.alarm_time);
        `AAT_OFF_IN_CAL_LO: n.rdata = 32'(q.in_cal_lo);
        `AAT_OFF_IN_CAL_HI: n.rdata = 32'(q.in_cal_hi);
        `AAT_OFF_IN_VALUE: n.rdata = 32'(ain_val);
        `AAT_OFF_OUT_VALUE: n.rdata = 32'(q.out_level); // R6
        `AAT_OFF_OUT_SRC: n.rdata = 32'(q.out_src);
        `AAT_OFF_OUT_FORCED: n.rdata = 32'(q.out_forced);
        `AAT_OFF_OUT_CAL_LO: n.rdata = 32'(q.out_cal_lo);
        `AAT_OFF_OUT_CAL_HI: n.rdata = 32'(q.out_cal_hi);
        `AAT_OFF_EYE_READ: n.rdata = 32'(q.eye_s2); // R14
        `AAT_OFF_EYE_STATE: n.rdata = 32'(q.eye_state);
        `AAT_OFF_EYE_MODE: n.rdata = 32'(q.eye_mode);
        `AAT_OFF_DET_TIME: n.rdata = 32'(q.det_time);
        `AAT_OFF_LIQ_THR: n.rdata = 32'(q.liq_thr);
        `AAT_OFF_AIR_THR: n.rdata = 32'(q.air_thr);
        `AAT_OFF_EVENTS: n.rdata = 32'(q.ev);
        default: n.err = 1'b1;
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.low_limit <= `AAT_RST_LOW_LIMIT;
      q.high_limit <= `AAT_RST_HIGH_LIMIT;
      q.alarm_time <= `AAT_RST_TIME;
      q.det_time <= `AAT_RST_TIME;
      q.in_cal_lo <= `AAT_RST_CAL_LO;
      q.in_cal_hi <= `AAT_RST_CAL_HI;
      q.out_cal_lo <= `AAT_RST_CAL_LO;
      q.out_cal_hi <= `AAT_RST_CAL_HI;
      q.liq_thr <= `AAT_RST_LIQ_THR;
      q.air_thr <= `AAT_RST_AIR_THR;
    end else begin
      q <= n;
    end
  end

  // outputs
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.err;
  assign dac_enable = q.out_en;
  assign events = q.ev;
endmodule
`default_nettype wire

// >>> aat_checker.sv
/*
  port checker for aat_monitor: apb answer, read data hold, event
  exclusivity and quiet events while the sensor is missing.
  assumes it is bound to aat_monitor with the same tick parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aat_consts.svh"
module aat_checker #(
  parameter int TICK_CYCLES = 10 // cycles per tick
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [`AAT_ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire aat_pkg::aat_word_t ain_raw, // adc pin
  input wire aat_pkg::aat_word_t eye_raw, // detector pin
  input wire logic eye_no_sensor, // no sensor pin
  input wire aat_pkg::aat_proc_t proc, // process values
  input wire aat_pkg::aat_word_t dac_code, // output code
  input wire logic dac_enable, // output driven
  input wire aat_pkg::aat_events_t events // alerts and faults
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmapped;
  logic [15:0] up_q;
  // addresses outside the word map
  assign unmapped = paddr > `AAT_OFF_EVENTS || paddr[1:0] != 2'h0;
  // cycles since reset, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 16'h0;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_unmapped: assert property (s_access ##0 unmapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_low_excl: assert property (!(events.low_alert && events.low_fault))
    else $error("low alert and fault together");
  a_high_excl: assert property (
    !(events.high_alert && events.high_fault))
    else $error("high alert and fault together");
  a_eye_excl: assert property (!(events.eye_alert && events.eye_fault))
    else $error("eye alert and fault together");
  a_nosens_quiet: assert property (
    eye_no_sensor [*8] |-> !(events.eye_alert || events.eye_fault))
    else $error("eye event without sensor");
  a_first_tick: assert property (up_q < TICK_CYCLES |-> events == '0)
    else $error("event before first tick");
endmodule
bind aat_monitor aat_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ain_raw(ain_raw),
  .eye_raw(eye_raw), .eye_no_sensor(eye_no_sensor), .proc(proc),
  .dac_code(dac_code), .dac_enable(dac_enable), .events(events));
`default_nettype wire

// >>> aat_front_model.sv
/*
  sensor front end: current loop adc word, optical tube reading and the
  missing sensor line, presented on pclk edges.
  assumes the bench sets the wanted values.
*/
`timescale 1ns/1ps
`default_nettype none
module aat_front_model (
  input wire logic pclk, // clock
  input wire aat_pkg::aat_word_t ain_set, // loop current wanted
  input wire aat_pkg::aat_word_t eye_set, // tube reading wanted
  input wire logic ns_set, // sensor unplugged
  output aat_pkg::aat_word_t ain_raw, // adc word
  output aat_pkg::aat_word_t eye_raw, // detector reading
  output logic eye_no_sensor // missing sensor level
);
  // the tube placed in the detector sets the reading
  always_ff @(posedge pclk) begin
    ain_raw <= ain_set;
    eye_raw <= eye_set;
    eye_no_sensor <= ns_set;
  end
endmodule
`default_nettype wire

// >>> aat_monitor_bench.sv
/*
  self-checking bench for aat_monitor: registers over apb, output
  sources, input correction, alarms and the tube detector.
  assumes aat_checker is bound and the tick is shortened to 10 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module aat_monitor_bench;
  localparam int TCK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ns;
  logic ns_raw, dac_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  aat_pkg::aat_word_t ain, eye, ain_raw, eye_raw, dac_code, fv;
  aat_pkg::aat_proc_t proc;
  aat_pkg::aat_events_t events;
  int failures, total_checks, cyc;
  logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h24, 8'h2C, 8'h30, 8'h3C, 8'h40, 8'h44, 8'h48};
  logic [15:0] rv [14] = '{16'h0, 16'h1000, 16'h0, 16'hF000, 16'h000A,
    16'h0, 16'hFFFF, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h000A, 16'hC000,
    16'h4000};
  // detector steps: mode, no sensor, reading, state, eye events
  int sm [8] = '{3, 3, 4, 5, 5, 0, 1, 2};
  logic sn [8] = '{0, 0, 0, 0, 1, 0, 0, 0};
  logic [15:0] se [8] = '{16'h1000, 16'hD000, 16'h1000, 16'h1000,
    16'h1000, 16'h1000, 16'h2345, 16'hABCD};
  int ss [8] = '{1, 2, 1, 1, 3, 0, 4, 5};
  logic [1:0] sv [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
  aat_front_model fm (.pclk(pclk), .ain_set(ain), .eye_set(eye),
    .ns_set(ns), .ain_raw(ain_raw), .eye_raw(eye_raw),
    .eye_no_sensor(ns_raw));
  aat_monitor #(.TICK_CYCLES(TCK)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ain_raw(ain_raw), .eye_raw(eye_raw), .eye_no_sensor(ns_raw),
    .proc(proc), .dac_code(dac_code), .dac_enable(dac_enable),
    .events(events));
  // free running clock
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task final_report;
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, result left in rd and er
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    check(rd, exp);
  endtask
  // expected output level for a source code
  function automatic logic [15:0] exp_level(int s);
    case (s)
      1: return proc.actual_rate;
      2: return proc.dispense_rate;
      3: return proc.feeder_rate;
      4: return proc.maint_setpoint;
      5: return proc.dispense_volume;
      6: return proc.piston_pos;
      7: return ain;
      8: return fv;
      10: return 16'hFFFF;
      default: return 16'h0;
    endcase
  endfunction
  // main sequence
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    ain = 16'h8000;
    eye = 16'h8000;
    ns = 0;
    proc = '0;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(32'h11638d6b));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    xfer(0, 8'h50, 0);
    check(er, 1);
    check(rd, 0);
    xfer(1, 8'h20, 32'hFFFF);
    check(er, 0);
    rdc(8'h20, 0);
    // output sources, illegal codes included
    proc <= {$urandom, $urandom, $urandom};
    ain <= 16'(16'h2000 + $urandom_range(16'hC000));
    fv = 16'($urandom);
    xfer(1, 8'h28, fv);
    for (int s = 0; s < 16; s++) begin
      xfer(1, 8'h24, s);
      repeat (6) @(posedge pclk);
      rdc(8'h20, exp_level(s));
      check(dac_code, exp_level(s));
      check(dac_enable, s >= 1 && s <= 10);
    end
    xfer(1, 8'h2C, 16'h1234);
    xfer(1, 8'h30, 16'h9ABC);
    for (int s = 9; s < 11; s++) begin
      xfer(1, 8'h24, s);
      repeat (6) @(posedge pclk);
      check(dac_code, s == 9 ? 16'h1234 : 16'h9ABC);
    end
    // input correction with an exact slope of three
    xfer(1, 8'h18, 16'h5555);
    ain <= 16'h1111;
    repeat (8) @(posedge pclk);
    rdc(8'h1C, 16'h3333);
    ain <= 16'h6000;
    repeat (8) @(posedge pclk);
    rdc(8'h1C, 16'hFFFF);
    xfer(1, 8'h18, 16'hFFFF);
    // alarms at the limit, with a short excursion
    xfer(1, 8'h10, 3);
    for (int h = 0; h < 2; h++) begin
      for (int m = 0; m < 3; m++) begin
        xfer(1, h ? 8'h08 : 8'h00, m);
        ain <= h ? 16'hF000 : 16'h1000;
        repeat (20) @(posedge pclk);
        check(events[3:0], 0);
        ain <= 16'h8000;
        repeat (2) @(posedge pclk);
        ain <= h ? 16'hF000 : 16'h1000;
        repeat (25) @(posedge pclk);
        check(events[3:0], 0);
        repeat (40) @(posedge pclk);
        check(events[3:0], (m == 0 ? 0 : m) << (2 * h));
        ain <= 16'h8000;
        repeat (8) @(posedge pclk);
        check(events[3:0], 0);
        xfer(1, h ? 8'h08 : 8'h00, 0);
      end
    end
    // detector modes, missing sensor and tuning
    xfer(1, 8'h40, 2);
    for (int i = 0; i < 8; i++) begin
      xfer(1, 8'h3C, sm[i]);
      ns <= sn[i];
      eye <= se[i];
      repeat (50) @(posedge pclk);
      rdc(8'h38, ss[i]);
      check(events[5:4], sv[i]);
      rdc(8'h34, se[i]);
    end
    rdc(8'h48, 16'h2345);
    rdc(8'h44, 16'hABCD);
    xfer(1, 8'h3C, 3);
    xfer(1, 8'h44, 16'h9000);
    eye <= 16'h1000;
    repeat (50) @(posedge pclk);
    eye <= 16'h9800;
    repeat (10) @(posedge pclk);
    rdc(8'h38, 1);
    repeat (40) @(posedge pclk);
    rdc(8'h38, 2);
    final_report;
  end
endmodule
`default_nettype wire
